// >>> logic/crc_ilv_regs.vh
// Constants for the block check and symbol interleaver
`ifndef CRC_ILV_REGS_VH
`define CRC_ILV_REGS_VH
`define CRC_WIDTH        32
`define CRC_POLY_DEFAULT 32'h04C11DB7
`define CRC_INIT         32'h00000000
`define CRC_XOR_OUT      32'hFFFFFFFF
`define CHECK_BYTE_POS   4'h8
`define BLOCK_SYMBOLS    66
`define BLOCK_PAIRS      33
`define FIFO_DEPTH       8
`define SYM_WIDTH        2
`endif

// >>> logic/sym_fifo.v
// Parameterised FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sym_fifo #(
  parameter WIDTH = 3,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             clk,
  input  wire             sys_rst,
  // Filling side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Draining side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage
  reg [AW:0]      wp_q;             // Write pointer with wrap bit
  reg [AW:0]      rp_q;             // Read pointer with wrap bit
  wire            full;             // No room left
  wire            empty;            // Nothing stored

  assign full      = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign empty     = (wp_q == rp_q);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rp_q[AW-1:0]];

  // Write side
  always @(posedge clk)
  begin
    if (in_valid && !full)
      mem[wp_q[AW-1:0]] <= in_data;
  end

  // Pointers
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wp_q <= {(AW+1){1'b0}};
      rp_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (in_valid && !full)
        wp_q <= wp_q + 1'b1;
      if (out_ready && !empty)
        rp_q <= rp_q + 1'b1;
    end
  end
endmodule // sym_fifo
`default_nettype wire

// >>> logic/crc_interleaver.v
// Block check generator/checker and 66-symbol interleaver
`timescale 1ns/1ps
`default_nettype none
`include "crc_ilv_regs.vh"
module crc_interleaver #(
  parameter [31:0] POLY  = `CRC_POLY_DEFAULT, // Generator polynomial
  parameter        DEPTH = `FIFO_DEPTH        // Output FIFO depth
) (
  // Clock and reset
  input  wire       clk,
  input  wire       sys_rst,
  // Mode
  input  wire       tx_mode,
  // Byte stream for the check engine
  input  wire       byte_valid,
  input  wire [7:0] byte_data,
  input  wire       byte_first,
  input  wire       byte_last_blk,
  input  wire [3:0] byte_index,
  output wire       byte_ready,
  output reg  [7:0] check_byte_q,
  output reg        check_valid_q,
  output reg        check_fail_flag,
  output reg        check_done_q,
  // Symbol stream in
  input  wire       sym_valid,
  input  wire [1:0] sym_data,
  input  wire       sym_sync,
  output wire       sym_ready,
  // Symbol stream out
  output wire       out_valid,
  input  wire       out_ready,
  output wire [1:0] out_data,
  output wire       out_sync
);
  localparam ST_FILL = 1'b0; // Collecting a block
  localparam ST_SEND = 1'b1; // Emitting the permuted block

  reg  [31:0] crc_q;            // Running remainder
  reg  [31:0] crc_d;            // Next remainder
  reg  [31:0] hold_q;           // Inverted check held for send/compare
  reg  [1:0]  chk_cnt_q;        // Check byte counter
  reg  [1:0]  blk_mem [0:65];   // Block symbol buffer
  reg         state_q;          // Block state
  reg  [6:0]  wr_q;             // Fill position
  reg  [6:0]  rd_q;             // Send position
  wire [6:0]  perm;             // Source symbol of the current send slot
  wire        sync_in;          // A sync symbol is offered this cycle
  reg  [31:0] rx_cmp_q;         // Received check bytes
  integer     i;                // Bit loop

  // Check engine: bytes MSB first, bitwise division
  always @*
  begin
    crc_d = byte_first ? `CRC_INIT : crc_q;
    for (i = 7; i >= 0; i = i - 1)
    begin
      if (crc_d[31] ^ byte_data[i])
        crc_d = {crc_d[30:0], 1'b0} ^ POLY;
      else
        crc_d = {crc_d[30:0], 1'b0};
    end
  end

  assign byte_ready = 1'b1;

  // Accumulate, emit or compare the check
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      crc_q           <= 32'h00000000;
      hold_q          <= 32'h00000000;
      rx_cmp_q        <= 32'h00000000;
      chk_cnt_q       <= 2'h0;
      check_byte_q    <= 8'h00;
      check_valid_q   <= 1'b0;
      check_fail_flag <= 1'b0;
      check_done_q    <= 1'b0;
    end
    else
    begin
      check_valid_q <= 1'b0;
      check_done_q  <= 1'b0;
      if (!tx_mode && byte_valid && byte_first)
        check_fail_flag <= 1'b0;
      if (byte_valid)
      begin
        if (!(byte_last_blk && byte_index >= `CHECK_BYTE_POS))
        begin
          // Covered byte of intermediate or last block
          crc_q <= crc_d;
          if (byte_last_blk && byte_index == `CHECK_BYTE_POS - 4'h1)
          begin
            // Last covered byte: latch the check, restart the receive byte count
            hold_q    <= crc_d ^ `CRC_XOR_OUT;
            chk_cnt_q <= 2'h0;
          end
        end
        else if (tx_mode)
        begin
          // Check field bytes, highest coefficient first
          check_byte_q  <= hold_q[31:24];
          hold_q        <= {hold_q[23:0], 8'h00};
          check_valid_q <= 1'b1;
        end
        else
        begin
          // Collect received check and compare on the fourth byte
          rx_cmp_q  <= {rx_cmp_q[23:0], byte_data};
          chk_cnt_q <= chk_cnt_q + 2'h1;
          if (chk_cnt_q == 2'h3)
          begin
            check_fail_flag <= ({rx_cmp_q[23:0], byte_data} != hold_q);
            check_done_q    <= 1'b1;
          end
        end
      end
    end
  end

  // Source symbol of output slot s; pairs go out by index mod 4, groups ascending
  function [6:0] slot_src;
    input [6:0] s;
    reg   [5:0] h; // Pair slot counted from the block start
    reg   [5:0] p; // Pair position within its group
    reg   [1:0] g; // Group, the pair index mod 4
    begin
      h = s[6:1];
      if (s < 7'd18)
      begin
        // Pairs 0, 4, ... 32
        g = 2'h0;
        p = h;
      end
      else if (s < 7'd34)
      begin
        // Pairs 1, 5, ... 29
        g = 2'h1;
        p = h - 6'd9;
      end
      else if (s < 7'd50)
      begin
        // Pairs 2, 6, ... 30
        g = 2'h2;
        p = h - 6'd17;
      end
      else
      begin
        // Pairs 3, 7, ... 31
        g = 2'h3;
        p = h - 6'd25;
      end
      slot_src = {p[3:0], g, s[0]};
    end
  endfunction

  // Transmit reads the block through the permutation
  assign perm = slot_src(rd_q);

  wire [1:0] fifo_in_data;   // Symbol entering output FIFO
  wire       fifo_in_valid;  // Symbol offered to FIFO
  wire       fifo_in_ready;  // FIFO has room
  wire [2:0] fifo_out;       // Symbol plus sync marker

  // A sync symbol bypasses the block buffer and pauses the block send
  assign sync_in       = sym_valid && sym_sync;
  assign fifo_in_valid = sync_in || (state_q == ST_SEND);
  assign fifo_in_data  = sync_in ? sym_data
                       : (tx_mode ? blk_mem[perm] : blk_mem[rd_q]);
  assign sym_ready     = sym_sync ? fifo_in_ready : (state_q == ST_FILL);

  // Fill and send sequencing
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= ST_FILL;
      wr_q    <= 7'h00;
      rd_q    <= 7'h00;
    end
    else
    begin
      case (state_q)
        ST_FILL:
        begin
          if (sym_valid && !sym_sync)
          begin
            wr_q <= (wr_q == 7'd65) ? 7'h00 : wr_q + 7'h01;
            if (wr_q == 7'd65)
              state_q <= ST_SEND;
          end
        end
        ST_SEND:
        begin
          if (fifo_in_ready && !sync_in)
          begin
            rd_q <= (rd_q == 7'd65) ? 7'h00 : rd_q + 7'h01;
            if (rd_q == 7'd65)
              state_q <= ST_FILL;
          end
        end
        default:
          state_q <= ST_FILL;
      endcase
    end
  end

  // Block buffer write; receive scatters through the permutation
  always @(posedge clk)
  begin
    if (state_q == ST_FILL && sym_valid && !sym_sync)
      blk_mem[tx_mode ? wr_q : slot_src(wr_q)] <= sym_data;
  end

  // Output FIFO in the symbol path
  sym_fifo #(
    .WIDTH (3),
    .DEPTH (DEPTH),
    .AW    (3)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   ({sync_in, fifo_in_data}),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (fifo_out)
  );

  assign out_data = fifo_out[1:0];
  assign out_sync = fifo_out[2];
endmodule // crc_interleaver
`default_nettype wire

// >>> bench/crc_ilv_assertions.sv
// Port checker for the block check and interleaver
`timescale 1ns/1ps
`default_nettype none
module crc_ilv_chk (
  // Watched ports
  input wire logic       clk, sys_rst, tx_mode, byte_valid, byte_first, byte_last_blk, byte_ready,
  input wire logic       check_valid_q, check_fail_flag, check_done_q, out_valid, out_ready, out_sync,
  input wire logic [3:0] byte_index,
  input wire logic [7:0] check_byte_q,
  input wire logic [1:0] out_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_byte_rdy_high: assert property (byte_ready) else $error("byte ready low");
  chk_check_cause: assert property (check_valid_q |-> $past(byte_valid && tx_mode && byte_last_blk))
    else $error("check byte without cause");
  chk_check_answer: assert property (byte_valid && tx_mode && byte_last_blk && byte_index >= 4'h8
    |=> check_valid_q) else $error("check byte missing");
  chk_check_stands: assert property ($changed(check_byte_q) |-> check_valid_q) else $error("check byte moved");
  chk_done_rx_only: assert property (check_done_q |-> !$past(tx_mode)) else $error("compare in transmit");
  chk_done_pulse: assert property (check_done_q |=> !check_done_q) else $error("compare done held");
  chk_flag_cause: assert property ($changed(check_fail_flag) |-> check_done_q || $past(byte_valid && byte_first))
    else $error("fail flag moved");
  chk_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_sync))
    else $error("output dropped");
endmodule // crc_ilv_chk
bind crc_interleaver crc_ilv_chk u_chk (
  .clk             (clk),
  .sys_rst         (sys_rst),
  .tx_mode         (tx_mode),
  .byte_valid      (byte_valid),
  .byte_first      (byte_first),
  .byte_last_blk   (byte_last_blk),
  .byte_ready      (byte_ready),
  .check_valid_q   (check_valid_q),
  .check_fail_flag (check_fail_flag),
  .check_done_q    (check_done_q),
  .out_valid       (out_valid),
  .out_ready       (out_ready),
  .out_sync        (out_sync),
  .byte_index      (byte_index),
  .check_byte_q    (check_byte_q),
  .out_data        (out_data)
);
`default_nettype wire

// >>> bench/sym_sink.sv
// Model of the symbol filter path draining the output
`timescale 1ns/1ps
`default_nettype none
module sym_sink (
  // Clock and reset
  input wire logic       clk, sys_rst,
  // Drained stream
  input wire logic       out_valid, out_sync,
  input wire logic [1:0] out_data,
  output logic           out_ready
);
  logic [1:0] cnt_q;  // Stall pacing
  logic [2:0] q [$];  // Accepted sync flag and symbol
  // Stall one cycle in four, take symbols on handshake
  always @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      cnt_q <= 2'h0;
      out_ready <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_q + 2'h1;
      out_ready <= (cnt_q != 2'h2);
      if (out_valid && out_ready) q.push_back({out_sync, out_data});
    end
endmodule // sym_sink
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking bench for the block check and interleaver
`timescale 1ns/1ps
`default_nettype none
`include "crc_ilv_regs.vh"
module testbench;
  logic       clk, sys_rst, tx_mode, byte_valid, byte_first, byte_last_blk, byte_ready;
  logic       sym_valid, sym_sync, sym_ready, out_ready, out_valid, out_sync;
  logic       check_valid_q, check_fail_flag, check_done_q;
  logic [3:0] byte_index;
  logic [7:0] byte_data, check_byte_q;
  logic [1:0] sym_data, out_data;
  logic [7:0] msg [0:19];  // Covered bytes of the frame
  logic [7:0] cq [$];      // Check bytes seen on transmit
  int         miscompares, n_tests, ord [0:65];
  crc_interleaver uut (.*);
  sym_sink snk (.*);
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Reference check: MSB first, plain remainder, inverted result
  function automatic logic [31:0] crc_of(int n);
    logic [31:0] c;
    c = 32'h00000000;
    for (int i = 0; i < n * 8; i++)
      c = {c[30:0], 1'b0} ^ ((c[31] ^ msg[i/8][7-i%8]) ? `CRC_POLY_DEFAULT : 32'h0);
    return ~c;
  endfunction
  function automatic logic [1:0] pat(int i);
    return 2'((i * 7 + i / 5) % 4);
  endfunction
  task automatic put_byte(logic [7:0] d, logic f, logic l, logic [3:0] i);
    byte_valid <= 1'b1;
    byte_data <= d;
    byte_first <= f;
    byte_last_blk <= l;
    byte_index <= i;
    @(posedge clk);
  endtask
  // One intermediate block, then the last block with its check field
  task automatic send_frame(logic [31:0] ck);
    for (int i = 0; i < 12; i++) put_byte(msg[i], i == 0, 1'b0, 4'(i));
    for (int i = 0; i < 12; i++) put_byte(i < 8 ? msg[12+i] : ck[31-8*(i-8) -: 8], 1'b0, 1'b1, 4'(i));
    byte_valid <= 1'b0;
  endtask
  task automatic t_tx_check;
    logic [31:0] e;
    e = crc_of(20);
    tx_mode <= 1'b1;
    @(posedge clk);
    send_frame(32'h0);
    repeat (4) @(posedge clk);
    chk("check count", cq.size(), 4);
    for (int k = 0; k < 4; k++) chk("check byte", cq[k], e[31-8*k -: 8]);
    $display("tx check test done");
  endtask
  task automatic t_rx_check(logic [31:0] flip, logic exp);
    tx_mode <= 1'b0;
    @(posedge clk);
    send_frame(crc_of(20) ^ flip);
    repeat (8) @(negedge clk) if (check_done_q === 1'b1) break;
    chk("compare done", check_done_q, 1);
    chk("fail flag", check_fail_flag, exp);
    $display("rx check test done");
  endtask
  task automatic put_sym(logic [1:0] d, logic s);
    sym_valid <= 1'b1;
    sym_data <= d;
    sym_sync <= s;
    do @(negedge clk); while (sym_ready !== 1'b1);
    @(posedge clk);
  endtask
  // Sync symbol, then one block, through the sink that stalls
  task automatic t_ilv(logic tx);
    tx_mode <= tx;
    snk.q.delete();
    @(posedge clk);
    put_sym(2'h3, 1'b1);
    for (int i = 0; i < 66; i++) put_sym(tx ? pat(i) : pat(ord[i]), 1'b0);
    sym_valid <= 1'b0;
    @(negedge clk);
    chk("block refused", sym_ready, 1'b0);
    repeat (400) @(negedge clk) if (snk.q.size() == 67) break;
    chk("sync symbol", snk.q[0], 3'h7);
    for (int j = 0; j < 66; j++) chk("symbol", snk.q[j+1], {1'b0, tx ? pat(ord[j]) : pat(j)});
    $display("symbol order test done");
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(negedge clk) if (check_valid_q === 1'b1) cq.push_back(check_byte_q);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #200000;
    miscompares++;
    results();
  end
  initial
  begin
    int j;
    {sys_rst, tx_mode, byte_valid, byte_first, byte_last_blk, sym_valid, sym_sync} = 7'h40;
    {byte_index, byte_data, sym_data} = 14'h0000;
    for (int i = 0; i < 20; i++) msg[i] = 8'(i * 37 + 5);
    j = 0;
    for (int g = 0; g < 4; g++)
      for (int p = g; p < 33; p += 4)
      begin
        ord[j] = 2 * p;
        ord[j+1] = 2 * p + 1;
        j += 2;
      end
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_tx_check();
    t_rx_check(32'h0, 1'b0);
    t_rx_check(32'h1, 1'b1);
    t_rx_check(32'h0, 1'b0);
    t_ilv(1'b1);
    t_ilv(1'b0);
    results();
  end
endmodule // testbench
`default_nettype wire
